// File: hdl/cfgva_top.sv
// What this block does
// - Write request is type 0x40, code 0x01; value selects destination.
// - Read request is type 0xC0, code 0x02; value selects source.
// - Index is first address, length is byte count, for both requests.
// - Serial memory writes into config space also update config registers.
// - Memory port is single master, standard mode, 100 kHz, no extras.
// - Serial clock is output only and never sampled.
// - Up to 2 Kbytes of memory addressable; config uses first 16.
// - Write value 0 is config bytes, 2 is memory; non-empty cfg outside 2..F stalls.
// - Config register writes leave the original data source untouched.
// - Memory write crossing a 256-byte page stalls.
// - Unsupported write destination or absent memory stalls.
// - Read value 0 cfg, 1 ROM, 2 memory, 3 identify data.
// - Read with any other source value stalls.
// - Read from absent memory, or identify data outside its mode, stalls.
// - Config byte read starting above 0xF stalls.
// - Clock high and low at least 5100 ns (51 cycles) each; bus free 5100 ns after stop.
// - Clock and data lines are open drain, only driving low.
`timescale 1ns/100ps
`default_nettype none
`include "cfgva_defs.svh"

module cfgva_top (
    input  wire logic                ref_clk,
    input  wire logic                rst_n,
    input  wire logic                setup_valid,
    input  wire cfgva_pkg::cfgva_setup_t setup,
    input  wire logic                wr_valid,
    input  wire logic [7:0]          wr_data,
    output logic                     wr_ready,
    output logic                     rd_valid,
    output logic [7:0]               rd_data,
    input  wire logic                rd_ready,
    output logic                     stall,
    output logic                     done,
    output logic                     busy,
    output logic [15:0]              aux_addr,
    output logic                     aux_sel_id,
    input  wire logic [7:0]          aux_data,
    input  wire logic                identify_data_mode,
    input  wire logic                eeprom_present,
    output logic [127:0]             cfg_bytes,
    output logic                     scl_o,
    output logic                     scl_oe,
    input  wire logic                sda_i,
    output logic                     sda_o,
    output logic                     sda_oe
);

    cfgva_pkg::cfgva_regs_t q;
    cfgva_pkg::cfgva_regs_t d;

    // ************************************************************
    // Request decode
    // ************************************************************
    logic        is_wr;
    logic        is_rd;
    logic [15:0] last_addr;
    logic        len_zero;
    logic        wr_bad;
    logic        rd_bad;
    logic [15:0] next_addr;
    logic        tmr_end;
    logic        last_byte;
    logic        rx_mode;
    logic        bit_drive;
    logic        in_cfg_space;

    assign is_wr = (setup.bm_type == `CFGVA_REQTYPE_WR) && (setup.b_req == `CFGVA_REQ_WR);
    assign is_rd = (setup.bm_type == `CFGVA_REQTYPE_RD) && (setup.b_req == `CFGVA_REQ_RD);
    assign last_addr = 16'(setup.w_index + setup.w_length - 16'h0001);
    assign len_zero  = (setup.w_length == 16'h0000);

    always_comb begin
        wr_bad = 1'b1;
        if (setup.w_value == `CFGVA_SEL_CFG) begin
            wr_bad = !len_zero && ((setup.w_index < `CFGVA_CFG_WR_LO) || (last_addr > `CFGVA_CFG_HI)
                     || (last_addr < setup.w_index));
        end else if (setup.w_value == `CFGVA_SEL_EE) begin
            wr_bad = !q.pres_s2 || (!len_zero && (setup.w_index[15:8] != last_addr[15:8]));
        end
    end

    always_comb begin
        case (setup.w_value)
            `CFGVA_SEL_CFG: rd_bad = (setup.w_index > `CFGVA_CFG_HI);
            `CFGVA_SEL_ROM: rd_bad = 1'b0;
            `CFGVA_SEL_EE:  rd_bad = !q.pres_s2;
            `CFGVA_SEL_ID:  rd_bad = !identify_data_mode;
            default:        rd_bad = 1'b1;
        endcase
    end

    assign next_addr    = 16'(q.addr + 16'h0001);
    assign tmr_end      = (q.tmr == 6'h00);
    assign last_byte    = (q.remain == 16'h0001);
    assign rx_mode      = (q.phase == `CFGVA_PH_RDATA);
    assign in_cfg_space = (q.addr >= `CFGVA_CFG_WR_LO) && (q.addr <= `CFGVA_CFG_HI);

    // Data bits, then acknowledge slot: master acks all read bytes but the last
    always_comb begin
        if (q.bitcnt != `CFGVA_LAST_BIT) begin
            bit_drive = rx_mode ? 1'b0 : ~q.shreg[7];
        end else begin
            bit_drive = rx_mode ? ~last_byte : 1'b0;
        end
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        d         = q;
        d.sda_s1  = sda_i;
        d.sda_s2  = q.sda_s1;
        d.pres_s1 = eeprom_present;
        d.pres_s2 = q.pres_s1;
        d.stall   = 1'b0;
        d.done    = 1'b0;
        d.scl_o   = 1'b0;
        d.sda_o   = 1'b0;
        if (!tmr_end) begin
            d.tmr = 6'(q.tmr - 6'h01);
        end
        case (q.st)
            cfgva_pkg::ST_IDLE: begin
                d.busy   = 1'b0;
                d.scl_oe = 1'b0;
                d.sda_oe = 1'b0;
                if (setup_valid && (is_wr || is_rd)) begin
                    d.is_read = is_rd;
                    d.addr    = setup.w_index;
                    d.remain  = setup.w_length;
                    if ((is_wr && wr_bad) || (is_rd && rd_bad)) begin
                        d.stall = 1'b1;
                    end else if (len_zero) begin
                        d.done = 1'b1;
                    end else begin
                        d.busy = 1'b1;
                        if (setup.w_value == `CFGVA_SEL_CFG) begin
                            if (is_wr) begin
                                d.st       = cfgva_pkg::ST_CFG_WR;
                                d.wr_ready = 1'b1;
                            end else begin
                                d.st       = cfgva_pkg::ST_CFG_RD;
                                d.rd_valid = 1'b1;
                                d.rd_data  = q.cfg[setup.w_index[3:0]];
                            end
                        end else if (setup.w_value == `CFGVA_SEL_EE) begin
                            d.st    = cfgva_pkg::ST_E_START;
                            d.sub   = 2'h0;
                            d.tmr   = `CFGVA_HALF_M1;
                            d.phase = `CFGVA_PH_CTRLW;
                            d.shreg = {`CFGVA_EE_CTRL, setup.w_index[`CFGVA_EE_BLK_HI:`CFGVA_EE_BLK_LO],
                                       `CFGVA_WR_BIT};
                        end else begin
                            d.st         = cfgva_pkg::ST_AUX_ADDR;
                            d.aux_sel_id = (setup.w_value == `CFGVA_SEL_ID);
                        end
                    end
                end
            end
            cfgva_pkg::ST_CFG_WR: begin
                if (wr_valid && q.wr_ready) begin
                    d.cfg[q.addr[3:0]] = wr_data;
                    d.addr   = next_addr;
                    d.remain = 16'(q.remain - 16'h0001);
                    if (last_byte) begin
                        d.wr_ready = 1'b0;
                        d.done     = 1'b1;
                        d.st       = cfgva_pkg::ST_IDLE;
                    end
                end
            end
            cfgva_pkg::ST_CFG_RD: begin
                if (rd_ready && q.rd_valid) begin
                    d.addr    = next_addr;
                    d.remain  = 16'(q.remain - 16'h0001);
                    d.rd_data = (next_addr <= `CFGVA_CFG_HI) ? q.cfg[next_addr[3:0]] : 8'h00;
                    if (last_byte) begin
                        d.rd_valid = 1'b0;
                        d.done     = 1'b1;
                        d.st       = cfgva_pkg::ST_IDLE;
                    end
                end
            end
            cfgva_pkg::ST_AUX_ADDR: begin
                d.aux_addr = q.addr;
                d.st       = cfgva_pkg::ST_AUX_WAIT;
            end
            cfgva_pkg::ST_AUX_WAIT: begin
                d.st = cfgva_pkg::ST_AUX_LATCH;
            end
            cfgva_pkg::ST_AUX_LATCH: begin
                d.rd_data  = aux_data;
                d.rd_valid = 1'b1;
                d.st       = cfgva_pkg::ST_AUX_SEND;
            end
            cfgva_pkg::ST_AUX_SEND: begin
                if (rd_ready && q.rd_valid) begin
                    d.rd_valid = 1'b0;
                    d.addr     = next_addr;
                    d.remain   = 16'(q.remain - 16'h0001);
                    if (last_byte) begin
                        d.done = 1'b1;
                        d.st   = cfgva_pkg::ST_IDLE;
                    end else begin
                        d.st = cfgva_pkg::ST_AUX_ADDR;
                    end
                end
            end
            cfgva_pkg::ST_E_START: begin
                if (tmr_end) begin
                    d.tmr = `CFGVA_HALF_M1;
                    if (q.sub == 2'h0) begin
                        d.sda_oe = 1'b1;
                        d.sub    = 2'h1;
                    end else begin
                        d.scl_oe = 1'b1;
                        d.half   = 1'b0;
                        d.bitcnt = 4'h0;
                        d.st     = cfgva_pkg::ST_E_BYTE;
                    end
                end
            end
            cfgva_pkg::ST_E_RSTART: begin
                if (tmr_end) begin
                    d.tmr = `CFGVA_HALF_M1;
                    case (q.sub)
                        2'h0: begin
                            d.scl_oe = 1'b0;
                            d.sub    = 2'h1;
                        end
                        2'h1: begin
                            d.sda_oe = 1'b1;
                            d.sub    = 2'h2;
                        end
                        default: begin
                            d.scl_oe = 1'b1;
                            d.half   = 1'b0;
                            d.bitcnt = 4'h0;
                            d.phase  = `CFGVA_PH_CTRLR;
                            d.shreg  = {`CFGVA_EE_CTRL, q.addr[`CFGVA_EE_BLK_HI:`CFGVA_EE_BLK_LO], `CFGVA_RD_BIT};
                            d.st     = cfgva_pkg::ST_E_BYTE;
                        end
                    endcase
                end
            end
            cfgva_pkg::ST_E_BYTE: begin
                if (!q.half) begin
                    // Data changes only after the clock has been low one cycle
                    if (q.tmr != `CFGVA_HALF_M1) begin
                        d.sda_oe = bit_drive;
                    end
                    if (tmr_end) begin
                        d.half   = 1'b1;
                        d.scl_oe = 1'b0;
                        d.tmr    = `CFGVA_HALF_M1;
                    end
                end else if (tmr_end) begin
                    d.scl_oe = 1'b1;
                    d.half   = 1'b0;
                    d.tmr    = `CFGVA_HALF_M1;
                    d.bitcnt = 4'(q.bitcnt + 4'h1);
                    if (q.bitcnt != `CFGVA_LAST_BIT) begin
                        d.shreg = {q.shreg[6:0], q.sda_s2};
                    end else begin
                        d.bitcnt = 4'h0;
                        case (q.phase)
                            `CFGVA_PH_CTRLW: begin
                                d.shreg = q.addr[7:0];
                                d.phase = `CFGVA_PH_ADDR;
                            end
                            `CFGVA_PH_ADDR: begin
                                if (q.is_read) begin
                                    d.st     = cfgva_pkg::ST_E_RSTART;
                                    d.sub    = 2'h0;
                                    d.sda_oe = 1'b0;
                                end else begin
                                    d.st       = cfgva_pkg::ST_E_LOAD;
                                    d.wr_ready = 1'b1;
                                end
                            end
                            `CFGVA_PH_WDATA: begin
                                d.addr   = next_addr;
                                d.remain = 16'(q.remain - 16'h0001);
                                if (last_byte) begin
                                    d.st  = cfgva_pkg::ST_E_STOP;
                                    d.sub = 2'h0;
                                end else begin
                                    d.st       = cfgva_pkg::ST_E_LOAD;
                                    d.wr_ready = 1'b1;
                                end
                            end
                            `CFGVA_PH_CTRLR: begin
                                d.phase = `CFGVA_PH_RDATA;
                            end
                            default: begin
                                d.st       = cfgva_pkg::ST_E_RXOUT;
                                d.rd_valid = 1'b1;
                                d.rd_data  = q.shreg;
                            end
                        endcase
                    end
                end
            end
            cfgva_pkg::ST_E_LOAD: begin
                if (wr_valid && q.wr_ready) begin
                    d.wr_ready = 1'b0;
                    d.shreg    = wr_data;
                    d.phase    = `CFGVA_PH_WDATA;
                    d.half     = 1'b0;
                    d.tmr      = `CFGVA_HALF_M1;
                    d.st       = cfgva_pkg::ST_E_BYTE;
                    if (in_cfg_space) begin
                        d.cfg[q.addr[3:0]] = wr_data;
                    end
                end
            end
            cfgva_pkg::ST_E_RXOUT: begin
                if (rd_ready && q.rd_valid) begin
                    d.rd_valid = 1'b0;
                    d.addr     = next_addr;
                    d.remain   = 16'(q.remain - 16'h0001);
                    d.half     = 1'b0;
                    d.tmr      = `CFGVA_HALF_M1;
                    if (last_byte) begin
                        d.st  = cfgva_pkg::ST_E_STOP;
                        d.sub = 2'h0;
                    end else begin
                        d.st = cfgva_pkg::ST_E_BYTE;
                    end
                end
            end
            cfgva_pkg::ST_E_STOP: begin
                if (q.sub == 2'h0 && q.tmr != `CFGVA_HALF_M1) begin
                    d.sda_oe = 1'b1;
                end
                if (tmr_end) begin
                    d.tmr = `CFGVA_HALF_M1;
                    if (q.sub == 2'h0) begin
                        d.scl_oe = 1'b0;
                        d.sub    = 2'h1;
                    end else begin
                        d.sda_oe = 1'b0;
                        d.st     = cfgva_pkg::ST_E_FREE;
                    end
                end
            end
            cfgva_pkg::ST_E_FREE: begin
                if (tmr_end) begin
                    d.done = 1'b1;
                    d.st   = cfgva_pkg::ST_IDLE;
                end
            end
            default: begin
                d.st = cfgva_pkg::ST_IDLE;
            end
        endcase
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign wr_ready   = q.wr_ready;
    assign rd_valid   = q.rd_valid;
    assign rd_data    = q.rd_data;
    assign stall      = q.stall;
    assign done       = q.done;
    assign busy       = q.busy;
    assign aux_addr   = q.aux_addr;
    assign aux_sel_id = q.aux_sel_id;
    assign cfg_bytes  = q.cfg;
    assign scl_o      = q.scl_o;
    assign scl_oe     = q.scl_oe;
    assign sda_o      = q.sda_o;
    assign sda_oe     = q.sda_oe;

endmodule

`default_nettype wire

// File: hdl/cfgva_defs.svh
`ifndef CFGVA_DEFS_SVH
`define CFGVA_DEFS_SVH

// ****************************************************************
// Request decode
// ****************************************************************
`define CFGVA_REQTYPE_WR 8'h40
`define CFGVA_REQ_WR     8'h01
`define CFGVA_REQTYPE_RD 8'hC0
`define CFGVA_REQ_RD     8'h02
`define CFGVA_SEL_CFG    16'h0000
`define CFGVA_SEL_ROM    16'h0001
`define CFGVA_SEL_EE     16'h0002
`define CFGVA_SEL_ID     16'h0003
`define CFGVA_CFG_WR_LO  16'h0002
`define CFGVA_CFG_HI     16'h000F

// ****************************************************************
// Serial memory addressing
// ****************************************************************
`define CFGVA_EE_CTRL    4'hA
`define CFGVA_EE_BLK_HI  10
`define CFGVA_EE_BLK_LO  8
`define CFGVA_RD_BIT     1'b1
`define CFGVA_WR_BIT     1'b0

// ****************************************************************
// Serial memory timing
// ****************************************************************
`define CFGVA_CLK_NS     100
`define CFGVA_T_HALF_NS  5066
`define CFGVA_HALF_CYC   ((`CFGVA_T_HALF_NS + `CFGVA_CLK_NS - 1) / `CFGVA_CLK_NS)
`define CFGVA_HALF_M1    6'(`CFGVA_HALF_CYC - 1)
`define CFGVA_LAST_BIT   4'h8
`define CFGVA_PH_CTRLW   3'h0
`define CFGVA_PH_ADDR    3'h1
`define CFGVA_PH_WDATA   3'h2
`define CFGVA_PH_CTRLR   3'h3
`define CFGVA_PH_RDATA   3'h4

`endif

// File: hdl/cfgva_pkg.sv
package cfgva_pkg;

    // ************************************************************
    // Control setup fields
    // ************************************************************
    typedef struct packed {
        logic [7:0]  bm_type;
        logic [7:0]  b_req;
        logic [15:0] w_value;
        logic [15:0] w_index;
        logic [15:0] w_length;
    } cfgva_setup_t;

    typedef enum logic [3:0] {
        ST_IDLE, ST_CFG_WR, ST_CFG_RD, ST_AUX_ADDR, ST_AUX_WAIT, ST_AUX_LATCH,
        ST_AUX_SEND, ST_E_START, ST_E_RSTART, ST_E_BYTE, ST_E_LOAD, ST_E_RXOUT,
        ST_E_STOP, ST_E_FREE
    } cfgva_state_t;

    // ************************************************************
    // Complete module state
    // ************************************************************
    typedef struct packed {
        cfgva_state_t    st;
        logic            is_read;
        logic [15:0]     addr;
        logic [15:0]     remain;
        logic [2:0]      phase;
        logic [1:0]      sub;
        logic            half;
        logic [3:0]      bitcnt;
        logic [5:0]      tmr;
        logic [7:0]      shreg;
        logic [15:0][7:0] cfg;
        logic            sda_s1;
        logic            sda_s2;
        logic            pres_s1;
        logic            pres_s2;
        logic            wr_ready;
        logic            rd_valid;
        logic [7:0]      rd_data;
        logic            stall;
        logic            done;
        logic            busy;
        logic [15:0]     aux_addr;
        logic            aux_sel_id;
        logic            scl_o;
        logic            scl_oe;
        logic            sda_o;
        logic            sda_oe;
    } cfgva_regs_t;

endpackage

// File: verification/cfgva_properties.sv
`timescale 1ns/100ps
`default_nettype none
module cfgva_properties (
    input wire logic                   ref_clk,
    input wire logic                   rst_n,
    input wire logic                   setup_valid,
    input wire cfgva_pkg::cfgva_setup_t setup,
    input wire logic                   busy,
    input wire logic                   stall,
    input wire logic                   done,
    input wire logic                   identify_data_mode,
    input wire logic                   scl_o,
    input wire logic                   sda_o,
    input wire logic                   scl_oe
);
    logic       last_q;
    logic [5:0] run_q;
    wire        take = setup_valid && !busy && !stall && !done;
    wire        wr = take && setup.bm_type == 8'h40 && setup.b_req == 8'h01;
    wire        rd = take && setup.bm_type == 8'hC0 && setup.b_req == 8'h02;
    // ****
    // Run length of the clock enable
    // ****
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            last_q <= 1'b0;
            run_q  <= 6'h00;
        end else begin
            last_q <= scl_oe;
            run_q  <= (scl_oe != last_q) ? 6'h00 : run_q + 6'(run_q != 6'h3F);
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    a_lines_low: assert property (scl_o == 1'b0 && sda_o == 1'b0) else $error("line driven high");
    a_stall_pulse: assert property (stall |-> !done ##1 !stall) else $error("stall not a pulse");
    a_done_pulse: assert property (done |=> !done) else $error("done not a pulse");
    a_wr_dest: assert property (wr && setup.w_value != 16'h0000 && setup.w_value != 16'h0002 |=> stall)
        else $error("bad write destination accepted");
    a_wr_low: assert property (wr && setup.w_value == 16'h0000 && setup.w_index < 16'h0002
        && setup.w_length != 16'h0000 |=> stall) else $error("config write below range accepted");
    a_rd_src: assert property (rd && setup.w_value > 16'h0003 |=> stall)
        else $error("bad read source accepted");
    a_rd_index: assert property (rd && setup.w_value == 16'h0000 && setup.w_index > 16'h000F |=> stall)
        else $error("config read above range accepted");
    a_id_mode: assert property (rd && setup.w_value == 16'h0003 && !identify_data_mode |=> stall)
        else $error("identify read outside mode accepted");
    a_rom_start: assert property (rd && setup.w_value == 16'h0001
        && setup.w_length != 16'h0000 |=> busy && !stall) else $error("rom read not started");
    a_scl_half: assert property (scl_oe != last_q |-> run_q >= 6'h32)
        else $error("clock phase too short");
endmodule
bind cfgva_top cfgva_properties cfgva_properties_inst (.*);
`default_nettype wire

// File: verification/cfgva_eeprom_model.sv
`timescale 1ns/100ps
`default_nettype none
module cfgva_eeprom_model (
    input wire logic  scl,
    input wire logic  sda,
    output var logic  sda_low
);
    logic [7:0]  mem [2048];
    logic [7:0]  sh;
    logic [10:0] a;
    int          n;
    int          st;
    initial begin
        sda_low = 1'b0;
        st = 0;
        for (int i = 0; i < 2048; i++) mem[i] = 8'(i) ^ 8'hA5 ^ 8'(i >> 8);
    end
    always @(negedge sda) if (scl) begin st = 1; n = 0; sda_low = 1'b0; end
    always @(posedge sda) if (scl) st = 0;
    always @(posedge scl) if (st != 0) begin
        if (st != 4) sh = {sh[6:0], sda};
        n = n + 1;
        if (st == 4 && n == 9 && sda) st = 0;
    end
    always @(negedge scl) if (st != 0) begin
        if (n == 9) begin
            n = 0;
            sda_low = 1'b0;
            if (st == 4) begin sh = mem[a]; a = a + 11'h001; sda_low = ~sh[7]; end
        end else if (n == 8) begin
            sda_low = (st != 4);
            if (st == 1) begin a[10:8] = sh[3:1]; st = sh[0] ? 4 : 2; end
            else if (st == 2) begin a[7:0] = sh; st = 3; end
            else if (st == 3) begin mem[a] = sh; a = a + 11'h001; end
        end else if (st == 4) sda_low = ~sh[7-n];
    end
endmodule
`default_nettype wire

// File: verification/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic ref_clk, rst_n, setup_valid, wr_valid, wr_ready, rd_valid, rd_ready, stall, done, busy;
    logic aux_sel_id, mode, pres, scl_o, scl_oe, sda_o, sda_oe, sda_low;
    logic [7:0] wr_data, rd_data, aux_data;
    logic [15:0] aux_addr;
    logic [127:0] cfg_bytes;
    cfgva_pkg::cfgva_setup_t setup;
    logic [7:0] cfg_m [16], ee_m [2048];
    int bad_count, num_checks, cyc, p;
    wire scl_w = scl_oe ? scl_o : 1'b1;
    wire sda_w = (sda_oe ? sda_o : 1'b1) & ~sda_low;
    assign aux_data = aux_addr[7:0] ^ aux_addr[15:8] ^ {aux_sel_id, 7'h35};
    cfgva_pkg::cfgva_setup_t tl [15] = '{64'h4001_0000_0002_000E, 64'hC002_0000_0000_0010,
        64'h4001_0000_0001_0002, 64'h4001_0000_000F_0002, 64'h4001_0001_0002_0001,
        64'h4001_0002_0008_0004, 64'h4001_0002_07F8_0010, 64'h4001_0002_05FF_0001,
        64'hC002_0002_0006_0004, 64'hC002_0002_05FF_0001, 64'hC002_0001_0100_0003,
        64'hC002_0003_0020_0002, 64'hC002_0004_0000_0001, 64'hC002_0000_0010_0001,
        64'hC002_0000_000E_0004};
    cfgva_top cfgva_top_inst (.ref_clk(ref_clk), .rst_n(rst_n), .setup_valid(setup_valid), .setup(setup),
        .wr_valid(wr_valid), .wr_data(wr_data), .wr_ready(wr_ready), .rd_valid(rd_valid), .rd_data(rd_data),
        .rd_ready(rd_ready), .stall(stall), .done(done), .busy(busy), .aux_addr(aux_addr),
        .aux_sel_id(aux_sel_id), .aux_data(aux_data), .identify_data_mode(mode), .eeprom_present(pres),
        .cfg_bytes(cfg_bytes), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe));
    cfgva_eeprom_model cfgva_eeprom_model_inst (.scl(scl_w), .sda(sda_w), .sda_low(sda_low));
    initial begin ref_clk = 1'b0; forever #50 ref_clk = ~ref_clk; end
    always @(posedge ref_clk) if (++cyc > 80000) begin bad_count++; give_verdict(); end
    task automatic tick(); @(posedge ref_clk); #1; endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(string nm, logic [127:0] e, logic [127:0] g);
        num_checks++;
        if (g !== e) begin bad_count++; $display("mismatch %s exp %0h got %0h", nm, e, g); end
    endtask
    function automatic bit refuse(cfgva_pkg::cfgva_setup_t s);
        int last;
        last = int'(s.w_index) + int'(s.w_length) - 1;
        if (s.bm_type == 8'h40) return !(s.w_value == 16'h0000 && s.w_index >= 2 && last <= 15) &&
            !(s.w_value == 16'h0002 && pres && s.w_index[15:8] == last[15:8]);
        return s.w_value > 3 || (s.w_value == 0 && s.w_index > 15) || (s.w_value == 2 && !pres) ||
            (s.w_value == 3 && !mode);
    endfunction
    function automatic logic [7:0] expv(logic [15:0] v, logic [15:0] a);
        if (v == 16'h0000) return a < 16 ? cfg_m[a] : 8'h00;
        if (v == 16'h0002) return ee_m[a[10:0]];
        return a[7:0] ^ a[15:8] ^ {v[1], 7'h35};
    endfunction
    function automatic logic [127:0] cfg_vec();
        logic [127:0] v;
        for (int i = 0; i < 16; i++) v[8*i +: 8] = cfg_m[i];
        return v;
    endfunction
    task automatic run(cfgva_pkg::cfgva_setup_t s);
        logic [7:0] wq[$], wd[$], rq[$];
        logic [15:0] a;
        bit took, ex;
        int n;
        took = 0;
        ex = refuse(s);
        for (int j = 0; j < s.w_length; j++) wq.push_back(8'($urandom));
        wd = wq;
        setup = s;
        setup_valid = 1'b1;
        tick();
        setup_valid = 1'b0;
        for (n = 0; n < 20000 && done !== 1'b1 && stall !== 1'b1; n++) begin
            if (took) void'(wq.pop_front());
            wr_valid = s.bm_type == 8'h40 && wq.size() > 0;
            wr_data = wr_valid ? wq[0] : 8'($urandom);
            took = wr_valid && wr_ready === 1'b1;
            rd_ready = 1'($urandom);
            if (rd_valid === 1'b1 && rd_ready) rq.push_back(rd_data);
            tick();
        end
        wr_valid = 1'b0;
        chk("answer", {ex, !ex}, {stall, done});
        if (!ex && s.bm_type == 8'hC0) begin
            chk("count", s.w_length, rq.size());
            foreach (rq[j]) chk("rd_data", expv(s.w_value, s.w_index + 16'(j)), rq[j]);
        end else if (!ex) foreach (wd[j]) begin
            a = s.w_index + 16'(j);
            if (s.w_value == 16'h0000 || (a >= 2 && a <= 15)) cfg_m[a] = wd[j];
            if (s.w_value == 16'h0002) ee_m[a[10:0]] = wd[j];
        end
        for (n = 0; n < 200 && busy !== 1'b0; n++) tick();
        chk("busy", 1'b0, busy);
        tick();
        chk("cfg_bytes", cfg_vec(), cfg_bytes);
    endtask
    initial begin
        void'($urandom(14));
        {rst_n, setup_valid, wr_valid, rd_ready, wr_data, setup, bad_count, num_checks, cyc} = '0;
        mode = 1'b1;
        pres = 1'b1;
        foreach (cfg_m[i]) cfg_m[i] = 8'h00;
        foreach (ee_m[i]) ee_m[i] = 8'(i) ^ 8'hA5 ^ 8'(i >> 8);
        repeat (3) tick();
        rst_n = 1'b1;
        for (p = 0; p < 2; p++) begin
            mode = (p == 0);
            pres = (p == 0);
            repeat (4) tick();
            foreach (tl[k]) run(tl[k]);
        end
        give_verdict();
    end
endmodule
`default_nettype wire
